// ---- rtl/bst_test_port.sv ----
// Boundary-scan test port with instruction, bypass, identification and boundary registers.
module bst_test_port
#(
  // Identification value is arbitrary.
  parameter logic [31:0] ID_CODE = 32'h1234_5671
)
(
  input wire logic clk,
  input wire logic resetn,
  input wire logic tck,
  input wire bst_pkg::bst_pad_s tms_pad,
  input wire bst_pkg::bst_pad_s tdi_pad,
  input wire bst_pkg::bst_pad_s trst_n_pad,
  output logic tdo,
  output logic tdo_oe,
  input wire bst_pkg::bst_pins_s core_pins,
  input wire logic [bst_pkg::BSR_LEN-1:0] pin_obs,
  output bst_pkg::bst_pins_s pins
);

  // ==========================================================
  // Pad inputs.
  logic tms_i;
  logic tdi_i;
  logic trst_n_i;

  assign tms_i = tms_pad.driven ? tms_pad.level : 1'b1;
  assign tdi_i = tdi_pad.driven ? tdi_pad.level : 1'b1;
  assign trst_n_i = trst_n_pad.driven ? trst_n_pad.level : 1'b1;

  // ==========================================================
  // Controller.
  bst_pkg::bst_state_e state;
  bst_tap_fsm u_fsm
  (
    .tck(tck),
    .trst_n(trst_n_i),
    .tms(tms_i),
    .state(state)
  );

  function automatic logic is_shift(input bst_pkg::bst_state_e s);
    return (s == bst_pkg::ST_SHIFT_DR) || (s == bst_pkg::ST_SHIFT_IR);
  endfunction

  // ==========================================================
  // Instruction register.
  logic [bst_pkg::IR_W-1:0] ir_sr_q;
  logic [bst_pkg::IR_W-1:0] ir_q;

  always_ff @(posedge tck or negedge trst_n_i)
  begin
    if (!trst_n_i)
    begin
      ir_sr_q <= bst_pkg::IR_CAPTURE;
      ir_q <= bst_pkg::IR_RESET;
    end
    else
    begin
      if (state == bst_pkg::ST_CAP_IR)
      begin
        ir_sr_q <= bst_pkg::IR_CAPTURE;
      end
      else if (state == bst_pkg::ST_SHIFT_IR)
      begin
        ir_sr_q <= {tdi_i, ir_sr_q[1]};
      end
      if (state == bst_pkg::ST_RESET)
      begin
        ir_q <= bst_pkg::IR_RESET;
      end
      else if (state == bst_pkg::ST_UPD_IR)
      begin
        ir_q <= ir_sr_q;
      end
    end
  end

  // ==========================================================
  // Instruction decode.
  // three data registers
  logic sel_bsr;
  logic sel_id;
  logic sel_byp;
  logic extest_tck;
  assign sel_byp = ir_q == bst_pkg::INS_BYPASS;
  assign sel_id = ir_q == bst_pkg::INS_IDCODE;
  assign extest_tck = ir_q == bst_pkg::INS_EXTEST;
  assign sel_bsr = extest_tck || (ir_q == bst_pkg::INS_SAMPLE);

  // ==========================================================
  // Bypass stage.
  logic bypass_q;
  always_ff @(posedge tck or negedge trst_n_i)
  begin
    if (!trst_n_i)
    begin
      bypass_q <= 1'b0;
    end
    else if (sel_byp && state == bst_pkg::ST_CAP_DR)
    begin
      bypass_q <= 1'b0;
    end
    else if (sel_byp && state == bst_pkg::ST_SHIFT_DR)
    begin
      bypass_q <= tdi_i;
    end
  end

  // ==========================================================
  // Identification register.
  logic [bst_pkg::ID_W-1:0] id_sr_q;

  always_ff @(posedge tck or negedge trst_n_i)
  begin
    if (!trst_n_i)
    begin
      id_sr_q <= '0;
    end
    else if (sel_id && state == bst_pkg::ST_CAP_DR)
    begin
      id_sr_q <= ID_CODE;
    end
    else if (sel_id && state == bst_pkg::ST_SHIFT_DR)
    begin
      id_sr_q <= {tdi_i, id_sr_q[bst_pkg::ID_W-1:1]};
    end
  end

  // ==========================================================
  // Boundary chain.
  logic [bst_pkg::BSR_LEN-1:0] obs_m_q;
  logic [bst_pkg::BSR_LEN-1:0] obs_s_q;
  logic [bst_pkg::BSR_LEN-1:0] bsr_sr_q;
  logic [bst_pkg::BSR_LEN-1:0] bsr_upd_q;
  logic upd_tgl_q;

  // Pin levels are synchronised into the test clock domain.
  always_ff @(posedge tck or negedge trst_n_i)
  begin
    if (!trst_n_i)
    begin
      obs_m_q <= '0;
      obs_s_q <= '0;
    end
    else
    begin
      obs_m_q <= pin_obs;
      obs_s_q <= obs_m_q;
    end
  end

  always_ff @(posedge tck or negedge trst_n_i)
  begin
    if (!trst_n_i)
    begin
      bsr_sr_q <= '0;
    end
    else if (sel_bsr && state == bst_pkg::ST_CAP_DR)
    begin
      bsr_sr_q <= obs_s_q;
    end
    else if (sel_bsr && state == bst_pkg::ST_SHIFT_DR)
    begin
      bsr_sr_q <= {tdi_i, bsr_sr_q[bst_pkg::BSR_LEN-1:1]};
    end
  end

  // Update stage and its toggle toward the functional clock.
  always_ff @(posedge tck or negedge trst_n_i)
  begin
    if (!trst_n_i)
    begin
      bsr_upd_q <= '0;
      upd_tgl_q <= 1'b0;
    end
    else if (sel_bsr && state == bst_pkg::ST_UPD_DR)
    begin
      bsr_upd_q <= bsr_sr_q;
      upd_tgl_q <= ~upd_tgl_q;
    end
  end

  // ==========================================================
  // Serial output.
  logic serial_out;
  logic tdo_q;
  logic tdo_oe_q;

  always_comb
  begin
    serial_out = bypass_q;
    if (state == bst_pkg::ST_SHIFT_IR)
    begin
      serial_out = ir_sr_q[0];
    end
    else if (sel_bsr)
    begin
      serial_out = bsr_sr_q[0];
    end
    else if (sel_id)
    begin
      serial_out = id_sr_q[0];
    end
  end

  always_ff @(negedge tck or negedge trst_n_i)
  begin
    if (!trst_n_i)
    begin
      tdo_q <= 1'b0;
      tdo_oe_q <= 1'b0;
    end
    else
    begin
      tdo_q <= serial_out;
      tdo_oe_q <= is_shift(state);
    end
  end

  assign tdo = tdo_q;
  assign tdo_oe = tdo_oe_q;

  // ==========================================================
  // Functional clock side.
  logic ext_m_q;
  logic ext_s_q;
  logic tgl_m_q;
  logic tgl_s_q;
  logic tgl_p_q;
  logic [bst_pkg::BSR_LEN-1:0] upd_clk_q;
  bst_pkg::bst_pins_s pins_q;

  function automatic logic [bst_pkg::BSR_LEN-1:0] oe_of(input logic [bst_pkg::BSR_LEN-1:0] c);
    logic [bst_pkg::BSR_LEN-1:0] oe;
    oe = '0;
    for (int i = 1; i < bst_pkg::BSR_LEN; i++)
    begin
      if (bst_pkg::OUT_MASK[i])
      begin
        oe[i] = bst_pkg::CTRL_MASK[i-1] ? c[i-1] : 1'b1;
      end
    end
    return oe;
  endfunction

  always_ff @(posedge clk)
  begin
    if (!resetn)
    begin
      ext_m_q <= 1'b0;
      ext_s_q <= 1'b0;
      tgl_m_q <= 1'b0;
      tgl_s_q <= 1'b0;
      tgl_p_q <= 1'b0;
    end
    else
    begin
      ext_m_q <= extest_tck;
      ext_s_q <= ext_m_q;
      tgl_m_q <= upd_tgl_q;
      tgl_s_q <= tgl_m_q;
      tgl_p_q <= tgl_s_q;
    end
  end

  // The update word is stable for a whole scan after each toggle.
  always_ff @(posedge clk)
  begin
    if (!resetn)
    begin
      upd_clk_q <= '0;
    end
    else if (tgl_s_q != tgl_p_q)
    begin
      upd_clk_q <= bsr_upd_q;
    end
  end

  // core runs untouched unless external test
  always_ff @(posedge clk)
  begin
    if (!resetn)
    begin
      pins_q <= '0;
    end
    else if (ext_s_q)
    begin
      pins_q.val <= upd_clk_q & bst_pkg::OUT_MASK;
      pins_q.oe <= oe_of(upd_clk_q);
    end
    else
    begin
      pins_q <= core_pins;
    end
  end

  assign pins = pins_q;

  // ==========================================================
  // Checks.
  // driver off outside shift
  tdo_hiz_a: assert property (@(posedge tck) disable iff (!trst_n_i)
    tdo_oe == is_shift(state))
    else $error("output enable does not follow shift state");

  bypass_path_a: assert property (@(posedge tck) disable iff (!trst_n_i)
    (sel_byp && state == bst_pkg::ST_SHIFT_DR) |=> bypass_q == $past(tdi_i))
    else $error("bypass stage did not take input bit");

  ir_shift_a: assert property (@(posedge tck) disable iff (!trst_n_i)
    state == bst_pkg::ST_SHIFT_IR |=> ir_sr_q == {$past(tdi_i), $past(ir_sr_q[1])})
    else $error("instruction shift wrong");

  ir_update_a: assert property (@(posedge tck) disable iff (!trst_n_i)
    state == bst_pkg::ST_UPD_IR |=> ir_q == $past(ir_sr_q))
    else $error("instruction not updated");

  id_capture_a: assert property (@(posedge tck) disable iff (!trst_n_i)
    (sel_id && state == bst_pkg::ST_CAP_DR) |=> id_sr_q == ID_CODE)
    else $error("identification value not captured");

  id_lsb_a: assert property (@(posedge tck) disable iff (!trst_n_i)
    (sel_id && state == bst_pkg::ST_SHIFT_DR) |-> tdo == id_sr_q[0])
    else $error("identification bit order wrong");

  bsr_order_a: assert property (@(posedge tck) disable iff (!trst_n_i)
    (sel_bsr && state == bst_pkg::ST_SHIFT_DR) |-> tdo == bsr_sr_q[0])
    else $error("boundary bit order wrong");

  tlr_instr_a: assert property (@(posedge tck) disable iff (!trst_n_i)
    state == bst_pkg::ST_RESET |=> ir_q == bst_pkg::IR_RESET)
    else $error("reset state kept old instruction");

  bsr_shift_a: assert property (@(posedge tck) disable iff (!trst_n_i)
    (sel_bsr && state == bst_pkg::ST_SHIFT_DR) |=> bsr_sr_q[bst_pkg::BSR_LEN-1] == $past(tdi_i))
    else $error("input bit not captured into chain");

  extest_drive_a: assert property (@(posedge clk) disable iff (!resetn)
    ext_s_q |=> pins.oe[1] == $past(upd_clk_q[0]))
    else $error("control cell did not set driver enable");

endmodule

// ---- rtl/bst_pkg.sv ----
// Constants, types and layout of the boundary-scan test port.
package bst_pkg;

  localparam int BSR_LEN = 118;
  localparam int ID_W = 32;
  localparam int IR_W = 2;

  localparam logic [1:0] INS_EXTEST = 2'h0;
  localparam logic [1:0] INS_IDCODE = 2'h1;
  localparam logic [1:0] INS_SAMPLE = 2'h2;
  localparam logic [1:0] INS_BYPASS = 2'h3;
  localparam logic [1:0] IR_CAPTURE = 2'h1;
  localparam logic [1:0] IR_RESET = INS_IDCODE;

  localparam int STO_PINS = 8;
  localparam int STO_LO_CTRL0 = 0;
  localparam int STO_HI_CTRL0 = 102;
  localparam int CSTO_CTRL = 17;
  localparam int DTA_OUT = 19;
  localparam int DBUS_PINS = 16;
  localparam int DBUS_CTRL0 = 20;

  typedef enum logic [3:0] {
    ST_RESET, ST_IDLE,
    ST_SEL_DR, ST_CAP_DR, ST_SHIFT_DR, ST_EXIT1_DR, ST_PAUSE_DR, ST_EXIT2_DR, ST_UPD_DR,
    ST_SEL_IR, ST_CAP_IR, ST_SHIFT_IR, ST_EXIT1_IR, ST_PAUSE_IR, ST_EXIT2_IR, ST_UPD_IR
  } bst_state_e;

  typedef struct packed {
    logic level;
    logic driven;
  } bst_pad_s;

  typedef struct packed {
    logic [BSR_LEN-1:0] val;
    logic [BSR_LEN-1:0] oe;
  } bst_pins_s;

  // Marks every tristate control cell of the chain.
  function automatic logic [BSR_LEN-1:0] ctrl_mask_f();
    logic [BSR_LEN-1:0] m;
    m = '0;
    for (int k = 0; k < STO_PINS; k++)
    begin
      m[STO_LO_CTRL0 + 2 * k] = 1'b1;
      m[STO_HI_CTRL0 + 2 * k] = 1'b1;
    end
    for (int k = 0; k < DBUS_PINS; k++)
    begin
      m[DBUS_CTRL0 + 3 * k] = 1'b1;
    end
    m[CSTO_CTRL] = 1'b1;
    return m;
  endfunction

  localparam logic [BSR_LEN-1:0] CTRL_MASK = ctrl_mask_f();
  localparam logic [BSR_LEN-1:0] DTA_BIT = 118'h1 << DTA_OUT;
  localparam logic [BSR_LEN-1:0] OUT_MASK = {CTRL_MASK[BSR_LEN-2:0], 1'b0} | DTA_BIT;

endpackage

// ---- rtl/bst_tap_fsm.sv ----
// Test access port controller state machine.
module bst_tap_fsm
(
  input wire logic tck,
  input wire logic trst_n,
  input wire logic tms,
  output bst_pkg::bst_state_e state
);

  bst_pkg::bst_state_e state_q;
  bst_pkg::bst_state_e state_d;

  always_comb
  begin
    unique case (state_q)
      bst_pkg::ST_RESET: state_d = tms ? bst_pkg::ST_RESET : bst_pkg::ST_IDLE;
      bst_pkg::ST_IDLE: state_d = tms ? bst_pkg::ST_SEL_DR : bst_pkg::ST_IDLE;
      bst_pkg::ST_SEL_DR: state_d = tms ? bst_pkg::ST_SEL_IR : bst_pkg::ST_CAP_DR;
      bst_pkg::ST_CAP_DR: state_d = tms ? bst_pkg::ST_EXIT1_DR : bst_pkg::ST_SHIFT_DR;
      bst_pkg::ST_SHIFT_DR: state_d = tms ? bst_pkg::ST_EXIT1_DR : bst_pkg::ST_SHIFT_DR;
      bst_pkg::ST_EXIT1_DR: state_d = tms ? bst_pkg::ST_UPD_DR : bst_pkg::ST_PAUSE_DR;
      bst_pkg::ST_PAUSE_DR: state_d = tms ? bst_pkg::ST_EXIT2_DR : bst_pkg::ST_PAUSE_DR;
      bst_pkg::ST_EXIT2_DR: state_d = tms ? bst_pkg::ST_UPD_DR : bst_pkg::ST_SHIFT_DR;
      bst_pkg::ST_UPD_DR: state_d = tms ? bst_pkg::ST_SEL_DR : bst_pkg::ST_IDLE;
      bst_pkg::ST_SEL_IR: state_d = tms ? bst_pkg::ST_RESET : bst_pkg::ST_CAP_IR;
      bst_pkg::ST_CAP_IR: state_d = tms ? bst_pkg::ST_EXIT1_IR : bst_pkg::ST_SHIFT_IR;
      bst_pkg::ST_SHIFT_IR: state_d = tms ? bst_pkg::ST_EXIT1_IR : bst_pkg::ST_SHIFT_IR;
      bst_pkg::ST_EXIT1_IR: state_d = tms ? bst_pkg::ST_UPD_IR : bst_pkg::ST_PAUSE_IR;
      bst_pkg::ST_PAUSE_IR: state_d = tms ? bst_pkg::ST_EXIT2_IR : bst_pkg::ST_PAUSE_IR;
      bst_pkg::ST_EXIT2_IR: state_d = tms ? bst_pkg::ST_UPD_IR : bst_pkg::ST_SHIFT_IR;
      bst_pkg::ST_UPD_IR: state_d = tms ? bst_pkg::ST_SEL_DR : bst_pkg::ST_IDLE;
    endcase
  end

  always_ff @(posedge tck or negedge trst_n)
  begin
    if (!trst_n)
    begin
      state_q <= bst_pkg::ST_RESET;
    end
    else
    begin
      state_q <= state_d;
    end
  end

  assign state = state_q;

  five_ones_a: assert property (@(posedge tck) disable iff (!trst_n)
    tms [*5] |=> state_q == bst_pkg::ST_RESET)
    else $error("five high mode selects did not reach reset");

  shift_hold_a: assert property (@(posedge tck) disable iff (!trst_n)
    (state_q == bst_pkg::ST_SHIFT_DR && !tms) |=> state_q == bst_pkg::ST_SHIFT_DR)
    else $error("shift state left with mode select low");

endmodule

// ---- testbench/bst_tester.sv ----
// Test controller model that drives the scan port from its own stopping clock.
module bst_tester
(
  output logic tck,
  output bst_pkg::bst_pad_s tms_pad,
  output bst_pkg::bst_pad_s tdi_pad,
  output bst_pkg::bst_pad_s trst_n_pad,
  input wire logic tdo,
  input wire logic tdo_oe
);
  timeunit 1ns;
  timeprecision 1ns;
  logic float_tms;
  logic float_tdi;

  // ====================================================================
  // Pads at rest.
  initial
  begin
    tck = 1'b0;
    float_tms = 1'b0;
    float_tdi = 1'b0;
    tms_pad = '{level: 1'b1, driven: 1'b1};
    tdi_pad = '{level: 1'b0, driven: 1'b1};
    trst_n_pad = '{level: 1'b0, driven: 1'b0};
  end

  // ====================================================================
  // Clock periods and scans.
  task automatic step(input logic tms_v, input logic tdi_v, output logic tdo_v, output logic oe_v);
    #2;
    tms_pad = '{level: float_tms ? ~tms_pad.level : tms_v, driven: ~float_tms};
    tdi_pad = '{level: float_tdi ? ~tdi_pad.level : tdi_v, driven: ~float_tdi};
    #28;
    tdo_v = tdo;
    oe_v = tdo_oe;
    #2 tck = 1'b1;
    #32 tck = 1'b0;
  endtask

  task automatic walk(input logic [7:0] seq, input int n);
    logic t;
    logic o;
    for (int i = 0; i < n; i++)
      step(seq[i], 1'b0, t, o);
  endtask

  task automatic scan(input logic ir, input int n, input logic [127:0] din,
                      output logic [127:0] dout, output int oe_bad);
    logic t;
    logic o;
    dout = '0;
    oe_bad = 0;
    walk(ir ? 8'h03 : 8'h01, ir ? 4 : 3);
    for (int i = 0; i < n; i++)
    begin
      step(i == n - 1, din[i], t, o);
      dout[i] = t;
      if (o !== 1'b1)
        oe_bad++;
    end
    walk(8'h01, 2);
  endtask

  task automatic pulse_trst();
    trst_n_pad = '{level: 1'b0, driven: 1'b1};
    #100;
    trst_n_pad = '{level: 1'b0, driven: 1'b0};
  endtask
endmodule

// ---- testbench/bst_test_port_test.sv ----
// Self-checking testbench of the boundary-scan test port.
module bst_test_port_test;
  timeunit 1ns;
  timeprecision 1ns;
  // Identification value is arbitrary.
  localparam logic [31:0] ID_VAL = 32'hA5C3_0F96;
  localparam logic [117:0] OBS = {2'h2, {29{4'h6}}, 4'h9};
  localparam logic [117:0] DIN = {2'h1, {29{4'hE}}, 4'h7};
  logic clk;
  logic resetn;
  logic tck;
  logic tdo;
  logic tdo_oe;
  bst_pkg::bst_pad_s tms_pad;
  bst_pkg::bst_pad_s tdi_pad;
  bst_pkg::bst_pad_s trst_n_pad;
  bst_pkg::bst_pins_s core_pins;
  bst_pkg::bst_pins_s pins;
  logic [117:0] pin_obs;
  logic [127:0] d;
  int bad;
  int fails;
  int cmp_count;

  // ====================================================================
  // Design and controller model.
  bst_test_port #(.ID_CODE(ID_VAL)) dut
  (
    .clk(clk),
    .resetn(resetn),
    .tck(tck),
    .tms_pad(tms_pad),
    .tdi_pad(tdi_pad),
    .trst_n_pad(trst_n_pad),
    .tdo(tdo),
    .tdo_oe(tdo_oe),
    .core_pins(core_pins),
    .pin_obs(pin_obs),
    .pins(pins)
  );

  bst_tester tester
  (
    .tck(tck),
    .tms_pad(tms_pad),
    .tdi_pad(tdi_pad),
    .trst_n_pad(trst_n_pad),
    .tdo(tdo),
    .tdo_oe(tdo_oe)
  );

  // ====================================================================
  // Checking and closing.
  task automatic check(input logic [235:0] got, input logic [235:0] exp);
    cmp_count++;
    if (got !== exp)
    begin
      fails++;
      $display("[FAIL] %0t got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic finish_test();
    if (fails == 0 && cmp_count > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask

  // ====================================================================
  // Scenarios.
  task automatic t_idcode();
    tester.pulse_trst();
    tester.walk(8'h00, 1);
    tester.scan(1'b0, 32, '0, d, bad);
    check(d, 128'(ID_VAL));
    check(bad, 0);
    check(tdo_oe, 1'b0);
  endtask

  task automatic t_bypass();
    tester.scan(1'b1, 2, 128'(bst_pkg::INS_BYPASS), d, bad);
    check(d, 128'(bst_pkg::IR_CAPTURE));
    tester.scan(1'b0, 8, 128'h00B4, d, bad);
    check(d, 128'({7'h34, 1'b0}));
  endtask

  task automatic t_boundary();
    tester.scan(1'b1, 2, 128'(bst_pkg::INS_SAMPLE), d, bad);
    tester.scan(1'b0, 120, 128'(DIN), d, bad);
    check(d, 128'({DIN[1:0], OBS}));
    @(posedge clk);
    #2;
    check(pins, core_pins);
  endtask

  task automatic t_extest();
    tester.scan(1'b1, 2, 128'(bst_pkg::INS_EXTEST), d, bad);
    tester.scan(1'b0, 118, 128'(DIN), d, bad);
    repeat (10) @(posedge clk);
    #2;
    check({pins.val[2:0], pins.oe[2:0], pins.oe[19], pins.oe[16], pins.oe[5]}, 9'h094);
  endtask

  task automatic t_pullup();
    tester.float_tms = 1'b1;
    tester.walk(8'h00, 5);
    tester.float_tms = 1'b0;
    tester.walk(8'h00, 1);
    tester.float_tdi = 1'b1;
    tester.scan(1'b0, 34, '0, d, bad);
    tester.float_tdi = 1'b0;
    check(d, 128'({2'b11, ID_VAL}));
  endtask

  // ====================================================================
  // Clock, reset and main sequence.
  initial
  begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end

  initial
  begin
    resetn = 1'b0;
    fails = 0;
    cmp_count = 0;
    core_pins = bst_pkg::bst_pins_s'({59{4'h5}});
    pin_obs = OBS;
    repeat (5) @(posedge clk);
    #2 resetn = 1'b1;
    t_idcode();
    t_bypass();
    t_boundary();
    t_extest();
    t_pullup();
    finish_test();
  end

  initial
  begin
    #200000;
    fails++;
    finish_test();
  end
endmodule
